// ===== rtl/ifc_flash_ctrl.sv
`timescale 1ns/1ps
module ifc_flash_ctrl #(
  parameter int UNLOCK_CYCLES = ifc_pkg::UNLOCK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Special-function register port
  input wire ifc_pkg::ifc_sfr_s sfr,
  output logic [7:0] sfr_rdata_ff,
  // Flash array
  output ifc_pkg::ifc_cmd_s fl_cmd_ff,
  output ifc_pkg::ifc_wdat_s fl_wdat_ff,
  input wire ifc_pkg::ifc_rsp_s fl_rsp,
  // System
  output logic cpu_stall_ff,
  output logic chip_rst_ff
);
  logic erase_write_enabled_ff;
  logic [2:0] mode_ff;
  logic unlock_ff;
  logic fwt_ff;
  logic read_enable_ff;
  logic frd_ff;
  logic buffer_clear_request_ff;
  logic [7:0] chip_pat_ff;
  logic [13:0] addr_ff;
  logic [3:0][7:0] dlo_ff;
  logic [3:0][7:0] dhi_ff;
  ifc_pkg::ifc_state_e st_ff;
  ifc_pkg::ifc_state_e nxt_st;
  logic [6:0] cnt_ff;
  logic pipe_ff;
  logic [5:0] pidx_ff;
  logic [15:0] buf_rdata;
  logic tmr_exp;
  logic clr_fwt;
  logic clr_frd;
  logic clr_buffer_clear_request;
  logic [15:0] unlock_age_ff;

  function automatic logic [1:0] data_slot(input logic [3:0] a);
    logic [3:0] d;
    d = a - ifc_pkg::REG_DATA_FIRST;
    return d[2:1];
  endfunction

  // Register decode
  wire wr = sfr.wr;
  wire [7:0] wd = sfr.wdata;
  wire wr_ctrl = wr && sfr.addr == ifc_pkg::REG_CTRL;
  wire wr_crst = wr && sfr.addr == ifc_pkg::REG_CHIP_RST;
  wire wr_bclr = wr && sfr.addr == ifc_pkg::REG_BUF_CLR;
  wire wr_alo = wr && sfr.addr == ifc_pkg::REG_ADDR_LO;
  wire wr_ahi = wr && sfr.addr == ifc_pkg::REG_ADDR_HI;
  wire in_data = sfr.addr >= ifc_pkg::REG_DATA_FIRST &&
    sfr.addr <= ifc_pkg::REG_DATA_LAST;
  // Even indices in the data range are high bytes
  wire wr_dhi = wr && in_data && !sfr.addr[0];
  wire wr_dlo = wr && in_data && sfr.addr[0];
  wire [1:0] slot = data_slot(sfr.addr);

  // Mode decode
  wire md_write = mode_ff == ifc_pkg::MODE_WRITE;
  wire md_erase = mode_ff == ifc_pkg::MODE_ERASE;
  wire md_read = mode_ff == ifc_pkg::MODE_READ;
  wire md_unlock = mode_ff == ifc_pkg::MODE_UNLOCK;

  // Unlock check at timer expiry
  wire pat_ok = dlo_ff[1] == ifc_pkg::PAT_LO1 &&
    dlo_ff[2] == ifc_pkg::PAT_LO2 && dlo_ff[3] == ifc_pkg::PAT_LO3 &&
    dhi_ff[1] == ifc_pkg::PAT_HI1 && dhi_ff[2] == ifc_pkg::PAT_HI2 &&
    dhi_ff[3] == ifc_pkg::PAT_HI3;
  wire unlock_ok = tmr_exp && md_unlock && pat_ok;
  wire tmr_start = wr_ctrl && wd[ifc_pkg::B_UNLOCK] && !unlock_ff;

  // Buffer load from the first data pair
  wire load_we = wr_dhi && slot == 2'd0 && erase_write_enabled_ff &&
    st_ff == ifc_pkg::ST_IDLE;
  wire at_last = addr_ff[5:0] == ifc_pkg::PAGE_LAST;
  wire clr_we = st_ff == ifc_pkg::ST_CLR;
  wire buf_we = clr_we || load_we;
  wire [5:0] buf_waddr = clr_we ? cnt_ff[5:0] : addr_ff[5:0];
  wire [15:0] buf_wdata = clr_we ? 16'h0000 : {wd, dlo_ff[0]};
  wire op_done = st_ff == ifc_pkg::ST_OP && fl_rsp.done;
  wire clr_end = clr_we && cnt_ff[5:0] == ifc_pkg::PAGE_LAST;
  wire wr_allowed = erase_write_enabled_ff && (md_write || md_erase);

  // Sequencer
  always_comb begin
    nxt_st = st_ff;
    clr_fwt = 1'b0;
    clr_frd = 1'b0;
    clr_buffer_clear_request = 1'b0;
    case (st_ff)
      ifc_pkg::ST_IDLE: begin
        if (fwt_ff) begin
          if (!wr_allowed) begin
            clr_fwt = 1'b1;
          end else if (md_write) begin
            nxt_st = ifc_pkg::ST_XFER;
          end else begin
            nxt_st = ifc_pkg::ST_OP;
          end
        end else if (frd_ff) begin
          if (read_enable_ff && md_read) begin
            nxt_st = ifc_pkg::ST_OP;
          end else begin
            clr_frd = 1'b1;
          end
        end else if (buffer_clear_request_ff) begin
          nxt_st = ifc_pkg::ST_CLR;
        end
      end
      ifc_pkg::ST_XFER: begin
        if (cnt_ff == ifc_pkg::XFER_END) begin
          nxt_st = ifc_pkg::ST_OP;
        end
      end
      ifc_pkg::ST_OP: begin
        if (fl_rsp.done) begin
          if (fl_cmd_ff.op == ifc_pkg::OP_WRITE) begin
            nxt_st = ifc_pkg::ST_CLR;
          end else begin
            nxt_st = ifc_pkg::ST_IDLE;
            clr_fwt = fl_cmd_ff.op == ifc_pkg::OP_ERASE;
            clr_frd = fl_cmd_ff.op == ifc_pkg::OP_READ;
          end
        end
      end
      ifc_pkg::ST_CLR: begin
        if (clr_end) begin
          nxt_st = ifc_pkg::ST_IDLE;
          clr_fwt = fl_cmd_ff.op == ifc_pkg::OP_WRITE;
          clr_buffer_clear_request = 1'b1;
        end
      end
      default: nxt_st = ifc_pkg::ST_IDLE;
    endcase
  end

  wire [1:0] nxt_op = fwt_ff ? (md_write ? ifc_pkg::OP_WRITE :
    ifc_pkg::OP_ERASE) : ifc_pkg::OP_READ;
  wire nxt_busy = nxt_st == ifc_pkg::ST_XFER ||
    nxt_st == ifc_pkg::ST_OP || (nxt_st == ifc_pkg::ST_CLR && fwt_ff);

  // Control register; a set from either side beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      erase_write_enabled_ff <= 1'b0;
      mode_ff <= 3'b000;
      unlock_ff <= 1'b0;
      fwt_ff <= 1'b0;
      read_enable_ff <= 1'b0;
      frd_ff <= 1'b0;
      buffer_clear_request_ff <= 1'b0;
      unlock_age_ff <= 16'h0000;
    end else begin
      if (unlock_ok) begin
        erase_write_enabled_ff <= 1'b1;
      end else if (wr_ctrl && !wd[ifc_pkg::B_ENABLED]) begin
        erase_write_enabled_ff <= 1'b0;
      end
      if (wr_ctrl) begin
        mode_ff <= wd[ifc_pkg::B_MODE_LSB +: 3];
        read_enable_ff <= wd[ifc_pkg::B_READ_EN];
      end
      if (tmr_start) begin
        unlock_ff <= 1'b1;
      end else if (tmr_exp) begin
        unlock_ff <= 1'b0;
      end
      fwt_ff <= (wr_ctrl && wd[ifc_pkg::B_WRITE_INIT]) ||
        (fwt_ff && !clr_fwt);
      frd_ff <= (wr_ctrl && wd[ifc_pkg::B_READ_INIT]) ||
        (frd_ff && !clr_frd);
      buffer_clear_request_ff <= (wr_bclr && wd[ifc_pkg::B_BUF_CLR]) ||
        (buffer_clear_request_ff && !clr_buffer_clear_request);
      unlock_age_ff <= unlock_ff ? unlock_age_ff + 16'h0001 : 16'h0000;
    end
  end

  // Address and data registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff <= 14'h0000;
      dlo_ff <= '0;
      dhi_ff <= '0;
      chip_pat_ff <= ifc_pkg::RESET_BYTE;
    end else begin
      if (wr_alo) begin
        addr_ff[7:0] <= wd;
      end
      if (wr_ahi) begin
        addr_ff[13:8] <= wd[5:0];
      end
      if (load_we && !at_last) begin
        addr_ff <= addr_ff + 14'h0001;
      end
      if (wr_crst) begin
        chip_pat_ff <= wd;
      end
      if (wr_dlo) begin
        dlo_ff[slot] <= wd;
      end
      if (wr_dhi) begin
        dhi_ff[slot] <= wd;
      end
      if (op_done && fl_cmd_ff.op == ifc_pkg::OP_READ) begin
        dlo_ff[0] <= fl_rsp.rdata[7:0];
        dhi_ff[0] <= fl_rsp.rdata[15:8];
      end
    end
  end

  // Read mux; unmapped indices read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (sfr.addr)
      ifc_pkg::REG_CTRL: rd_mux = {erase_write_enabled_ff, mode_ff, unlock_ff, fwt_ff,
        read_enable_ff, frd_ff};
      ifc_pkg::REG_CHIP_RST: rd_mux = chip_pat_ff;
      ifc_pkg::REG_BUF_CLR: rd_mux = {7'h00, buffer_clear_request_ff};
      ifc_pkg::REG_ADDR_LO: rd_mux = addr_ff[7:0];
      ifc_pkg::REG_ADDR_HI: rd_mux = {2'b00, addr_ff[13:8]};
      default: rd_mux = !in_data ? 8'h00 :
        (sfr.addr[0] ? dlo_ff[slot] : dhi_ff[slot]);
    endcase
  end

  // Sequencer registers and flash-side outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ifc_pkg::ST_IDLE;
      cnt_ff <= 7'h00;
      pipe_ff <= 1'b0;
      pidx_ff <= 6'h00;
      fl_cmd_ff <= '0;
      fl_wdat_ff <= '0;
      cpu_stall_ff <= 1'b0;
      chip_rst_ff <= 1'b0;
      sfr_rdata_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= (nxt_st == st_ff) ? cnt_ff + 7'h01 : 7'h00;
      // Buffer read is registered, so data trails the index by a stage
      pipe_ff <= st_ff == ifc_pkg::ST_XFER && !cnt_ff[6];
      pidx_ff <= cnt_ff[5:0];
      fl_wdat_ff <= '{valid: pipe_ff, idx: pidx_ff, data: buf_rdata};
      fl_cmd_ff.req <= nxt_st == ifc_pkg::ST_OP;
      if (st_ff == ifc_pkg::ST_IDLE) begin
        fl_cmd_ff.op <= nxt_op;
        fl_cmd_ff.addr <= addr_ff;
      end
      cpu_stall_ff <= nxt_busy;
      chip_rst_ff <= wr_crst && wd == ifc_pkg::CHIP_RESET_KEY;
      if (sfr.rd) begin
        sfr_rdata_ff <= rd_mux;
      end
    end
  end

  ifc_wbuf u_wbuf (
    .clk(clk),
    .arst_n(arst_n),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(cnt_ff[5:0]),
    .rdata_ff(buf_rdata)
  );

  ifc_timer #(.CYCLES(UNLOCK_CYCLES)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(tmr_start),
    .expire_ff(tmr_exp)
  );
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_write_done;
    op_done && fl_cmd_ff.op == ifc_pkg::OP_WRITE;
  endsequence
  sequence s_clear_walk;
    (st_ff == ifc_pkg::ST_CLR)[*8];
  endsequence
  a_enabled_no_sw_set: assert property (
    wr_ctrl && wd[7] && !erase_write_enabled_ff && !unlock_ok |=> !erase_write_enabled_ff)
    else $error("enabled bit set by software");
  a_enabled_sw_clear: assert property (
    wr_ctrl && !wd[7] && !unlock_ok |=> !erase_write_enabled_ff)
    else $error("enabled bit not cleared");
  a_enabled_by_unlock: assert property (
    $rose(erase_write_enabled_ff) |-> $past(tmr_exp) && $past(md_unlock) &&
    $past(pat_ok)) else $error("enable without good pattern");
  a_unlock_timeout: assert property (
    unlock_ff |-> unlock_age_ff <= 16'(UNLOCK_CYCLES))
    else $error("unlock trigger not cleared");
  a_read_blocked: assert property (
    st_ff == ifc_pkg::ST_IDLE && frd_ff && !fwt_ff && !read_enable_ff
    |=> !fl_cmd_ff.req ##1 !fl_cmd_ff.req)
    else $error("read ran while disabled");
  a_stall_op: assert property (
    fl_cmd_ff.req |-> cpu_stall_ff) else $error("core not stalled");
  a_chip_reset: assert property (
    wr_crst |=> chip_rst_ff == ($past(wd) == 8'h55))
    else $error("chip reset mismatch");
  a_addr_bump: assert property (
    load_we && !at_last && !wr_alo |=> addr_ff == $past(addr_ff) + 14'h1)
    else $error("address not incremented");
  a_addr_hold: assert property (
    load_we && at_last |=> addr_ff == $past(addr_ff))
    else $error("address passed page end");
  a_buf_autoclr: assert property (
    s_write_done |=> s_clear_walk ##[56:56] clr_end ##1 !fwt_ff)
    else $error("buffer not cleared after write");
  a_clr_bit_end: assert property (
    clr_end && !wr_bclr |=> !buffer_clear_request_ff)
    else $error("clear bit not released");
endmodule

// ===== rtl/ifc_pkg.sv
package ifc_pkg;
  // Register indices on the special-function port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CHIP_RST = 4'h1;
  localparam logic [3:0] REG_BUF_CLR = 4'h2;
  localparam logic [3:0] REG_ADDR_LO = 4'h3;
  localparam logic [3:0] REG_ADDR_HI = 4'h4;
  localparam logic [3:0] REG_DATA_FIRST = 4'h5;
  localparam logic [3:0] REG_DATA_LAST = 4'hC;
  // Control and buffer-clear register bit positions
  localparam int B_ENABLED = 7;
  localparam int B_MODE_LSB = 4;
  localparam int B_UNLOCK = 3;
  localparam int B_WRITE_INIT = 2;
  localparam int B_READ_EN = 1;
  localparam int B_READ_INIT = 0;
  localparam int B_BUF_CLR = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  localparam logic [5:0] PAGE_LAST = 6'h3F;
  localparam logic [6:0] XFER_END = 7'h41;
  localparam int UNLOCK_CYCLES_DEF = 1024;
  // Unlock pattern, words 1..3, low then high bytes
  localparam logic [7:0] PAT_LO1 = 8'h00;
  localparam logic [7:0] PAT_LO2 = 8'h0D;
  localparam logic [7:0] PAT_LO3 = 8'hC3;
  localparam logic [7:0] PAT_HI1 = 8'h04;
  localparam logic [7:0] PAT_HI2 = 8'h09;
  localparam logic [7:0] PAT_HI3 = 8'h40;

  typedef enum logic [2:0] {
    MODE_WRITE = 3'b000,
    MODE_ERASE = 3'b001,
    MODE_READ = 3'b011,
    MODE_UNLOCK = 3'b110
  } ifc_mode_e;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_ERASE = 2'b01,
    OP_READ = 2'b11
  } ifc_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CLR = 2'b01,
    ST_XFER = 2'b10,
    ST_OP = 2'b11
  } ifc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ifc_sfr_s;

  typedef struct packed {
    logic req;
    logic [1:0] op;
    logic [13:0] addr;
  } ifc_cmd_s;

  typedef struct packed {
    logic valid;
    logic [5:0] idx;
    logic [15:0] data;
  } ifc_wdat_s;

  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } ifc_rsp_s;
endpackage

// ===== rtl/ifc_wbuf.sv
`timescale 1ns/1ps
module ifc_wbuf (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Write port
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [15:0] wdata,
  // Read port
  input wire logic [5:0] raddr,
  output logic [15:0] rdata_ff
);
  logic [15:0] mem [64];

  // Array has no reset; contents are zeroed by the clear walk
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end
endmodule

// ===== rtl/ifc_timer.sv
`timescale 1ns/1ps
module ifc_timer #(
  parameter int CYCLES = 1024
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  output logic expire_ff
);
  logic [15:0] cnt_ff;
  logic run_ff;
  wire last = cnt_ff == 16'(CYCLES - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 16'h0000;
      run_ff <= 1'b0;
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= run_ff & last;
      if (start && !run_ff) begin
        run_ff <= 1'b1;
        cnt_ff <= 16'h0000;
      end else if (run_ff) begin
        run_ff <= !last;
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
endmodule

// ===== bench/ifc_flash_model.sv
`timescale 1ns/1ps
module ifc_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Controller side
  input wire ifc_pkg::ifc_cmd_s cmd,
  input wire ifc_pkg::ifc_wdat_s wdat,
  output ifc_pkg::ifc_rsp_s rsp_ff,
  // Answer latency in cycles, at least 1
  input wire logic [7:0] lat
);
  logic [15:0] mem [64];
  logic [15:0] pend [64];
  logic [8:0] cnt_ff;
  wire fire = cmd.req && (cnt_ff == {1'b0, lat});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      rsp_ff <= '0;
    end else begin
      rsp_ff.done <= fire;
      // Stale data toggles so nothing can lean on it
      rsp_ff.rdata <= ~rsp_ff.rdata;
      if (!cmd.req) begin
        cnt_ff <= '0;
      end else if (cnt_ff <= {1'b0, lat}) begin
        cnt_ff <= cnt_ff + 9'd1;
      end
      if (wdat.valid) begin
        pend[wdat.idx] <= wdat.data;
      end
      if (fire && cmd.op == ifc_pkg::OP_READ) begin
        rsp_ff.rdata <= mem[cmd.addr[5:0]];
      end
      if (fire && cmd.op == ifc_pkg::OP_WRITE) begin
        mem <= pend;
      end
      if (fire && cmd.op == ifc_pkg::OP_ERASE) begin
        foreach (mem[i]) mem[i] <= '0;
      end
    end
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Short timer keeps the unlock window brief
  localparam int UNLOCK = 32;
  logic clk;
  logic arst_n;
  ifc_pkg::ifc_sfr_s sfr;
  logic [7:0] rdata;
  ifc_pkg::ifc_cmd_s cmd;
  ifc_pkg::ifc_wdat_s wdat;
  ifc_pkg::ifc_rsp_s rsp;
  logic stall;
  logic crst;
  logic [7:0] lat;
  logic [7:0] v;
  logic [15:0] w0, w1, w2, got;
  logic [5:0] ahi;
  logic req_q;
  int bad_count, samples_checked, cycles, req_rises, crst_pulses;
  int unstalled, n;

  ifc_flash_ctrl #(.UNLOCK_CYCLES(UNLOCK)) i_dut (
    .clk(clk), .arst_n(arst_n), .sfr(sfr), .sfr_rdata_ff(rdata),
    .fl_cmd_ff(cmd), .fl_wdat_ff(wdat), .fl_rsp(rsp),
    .cpu_stall_ff(stall), .chip_rst_ff(crst));
  ifc_flash_model i_flash (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .wdat(wdat),
    .rsp_ff(rsp), .lat(lat));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    req_q <= cmd.req;
    if (cmd.req === 1'b1 && req_q !== 1'b1) req_rises++;
    if (cmd.req === 1'b1 && stall !== 1'b1) unstalled++;
    if (crst === 1'b1) crst_pulses++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk);
    sfr.rd = 1'b0;
    d = rdata;
  endtask

  // Polls a self-clearing bit; bounded so a stuck bit cannot hang
  task automatic wait_clr(input logic [3:0] a, input int b,
                          output logic [7:0] d);
    for (int i = 0; i < 400; i++) begin
      rd(a, d);
      if (d[b] === 1'b0) break;
    end
  endtask

  task automatic unlock(input logic [7:0] c, input logic [7:0] lo3);
    wr(4'h0, c);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h04);
    wr(4'h9, 8'h0D);
    wr(4'hA, 8'h09);
    wr(4'hB, lo3);
    wr(4'hC, 8'h40);
    wait_clr(4'h0, 3, v);
    check("unlock trigger", {15'h0, v[3]}, 16'h0);
  endtask

  task automatic op(input logic [7:0] c, input int b);
    lat = 8'($urandom_range(60, 1));
    wr(4'h0, c);
    wait_clr(4'h0, b, v);
    check("initiate bit", {15'h0, v[b]}, 16'h0);
  endtask

  task automatic rdw(input logic [7:0] a, output logic [15:0] w);
    logic [7:0] t;
    wr(4'h3, a);
    op(8'hB3, 0);
    rd(4'h5, t);
    w[7:0] = t;
    rd(4'h6, t);
    w[15:8] = t;
  endtask

  initial begin
    sfr = '0;
    arst_n = 1'b0;
    lat = 8'd3;
    req_q = 1'b0;
    void'($urandom(20));
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    for (int a = 0; a < 14; a++) begin
      rd(a[3:0], v);
      check("reset value", {8'h0, v}, 16'h0);
    end
    wr(4'h0, 8'h80);
    rd(4'h0, v);
    check("enable by software", {15'h0, v[7]}, 16'h0);
    wr(4'h4, 8'hFF);
    rd(4'h4, v);
    check("address high", {8'h0, v}, 16'h003F);
    unlock(8'h68, 8'hC2);
    check("bad pattern", {15'h0, v[7]}, 16'h0);
    unlock(8'h08, 8'hC3);
    check("wrong mode", {15'h0, v[7]}, 16'h0);
    unlock(8'h68, 8'hC3);
    check("unlocked", {15'h0, v[7]}, 16'h1);
    ahi = 6'($urandom);
    wr(4'h4, {2'b00, ahi});
    wr(4'h3, 8'h3E);
    n = req_rises;
    op(8'h94, 2);
    check("erase request", 16'(req_rises), 16'(n + 1));
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    w2 = 16'($urandom);
    wr(4'h5, w0[7:0]);
    rd(4'h3, v);
    check("address after low", {8'h0, v}, 16'h003E);
    wr(4'h6, w0[15:8]);
    rd(4'h3, v);
    check("address bump", {8'h0, v}, 16'h003F);
    wr(4'h5, w1[7:0]);
    wr(4'h6, w1[15:8]);
    wr(4'h5, w2[7:0]);
    wr(4'h6, w2[15:8]);
    rd(4'h3, v);
    check("address hold", {8'h0, v}, 16'h003F);
    wr(4'h3, 8'h3E);
    op(8'h84, 2);
    rdw(8'h3E, got);
    check("word 62", got, w0);
    rdw(8'h3F, got);
    check("word 63", got, w2);
    op(8'h84, 2);
    rdw(8'h3E, got);
    check("buffer after write", got, 16'h0);
    n = req_rises;
    op(8'hB1, 0);
    for (int m = 2; m < 8; m++) begin
      if (m == 3 || m == 6) continue;
      op(8'h84 | 8'(m << 4), 2);
    end
    check("refused requests", 16'(req_rises), 16'(n));
    wr(4'h2, 8'h01);
    wait_clr(4'h2, 0, v);
    check("buffer clear", {8'h0, v}, 16'h0);
    wr(4'h0, 8'h00);
    rd(4'h0, v);
    check("disable", {15'h0, v[7]}, 16'h0);
    n = req_rises;
    op(8'h14, 2);
    check("locked erase", 16'(req_rises), 16'(n));
    check("stall during op", 16'(unstalled), 16'h0);
    n = crst_pulses;
    wr(4'h1, 8'h54);
    wr(4'h1, 8'h55);
    repeat (2) @(negedge clk);
    check("chip reset", 16'(crst_pulses), 16'(n + 1));
    finish_test();
  end
endmodule
